//--- design/hfl_link.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module hfl_link
  import hfl_pkg::*;
#(
  parameter int unsigned DIV_FAST_P = DIV_FAST,
  parameter int unsigned DIV_SLOW_P = DIV_SLOW,
  parameter int unsigned DEADMAN_P  = DEADMAN_CYC
) (
  input  wire logic       CLK_I,        // 125 MHz clock
  input  wire logic       SRST_I,       // Sync reset, high
  input  wire logic [7:0] ADDR_I,       // Board sel [7:4], reg [3:0]
  input  wire logic [7:0] WDATA_I,      // Write data
  input  wire logic       WR_I,         // Write strobe
  input  wire logic       RD_I,         // Read strobe
  input  wire logic [3:0] ADDR_SW_I,    // address_select_switch, BCD
  input  wire logic       TEST_SW_I,    // test_mode_switch, high=test
  input  wire logic       RXD_I,        // Demodulated receive data
  input  wire logic       CARRIER_I,    // Peak detector, high=tone
  output logic      [7:0] RDATA_O,      // Read data, cycle after read
  output logic            BUS_DRV_EN_O, // Data drivers enabled
  output logic            BUS_DIR_O,    // 1: board drives bus
  output logic            TXD_O,        // Serial transmit data
  output logic            FREQ_SEL_O,   // 1: 1200 Hz, 0: 2200 Hz
  output logic            MOD_EN_O,     // Modulator enable
  output logic            DCD_N_O,      // Carrier detect, low active
  output logic            IRQ_O         // Level interrupt
);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  // ==========================================================
  // Pin synchronisers
  logic [NPIN-1:0] s1, s2, s3, flt, next_flt;
  logic            rx_lvl, rx_prev, cd_on, test_on;
  logic [3:0]      sw;

  always_comb begin
    // A change only counts once the two later stages agree
    next_flt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & flt);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s1      <= '0;
      s2      <= '0;
      s3      <= '0;
      flt     <= 7'h01;
      rx_prev <= 1'b1;
    end else begin
      s1      <= {ADDR_SW_I, TEST_SW_I, CARRIER_I, RXD_I};
      s2      <= s1;
      s3      <= s2;
      flt     <= next_flt;
      rx_prev <= flt[PIN_RXD];
    end
  end

  assign rx_lvl  = flt[PIN_RXD];
  assign cd_on   = flt[PIN_CD];
  assign test_on = flt[PIN_TEST];
  assign sw      = flt[PIN_SW +: 4];

  // ==========================================================
  // Baud generator, 16 ticks per bit
  hfl_ctrl_t   ctrl, next_ctrl;
  logic [14:0] div_cnt, next_div_cnt;
  logic        tick, next_tick;

  always_comb begin
    logic [14:0] lim;
    lim = ctrl.baud_slow ? 15'(DIV_SLOW_P - 1)
                         : 15'(DIV_FAST_P - 1);
    next_tick    = 1'b0;
    next_div_cnt = div_cnt + 15'h0001;
    if (div_cnt >= lim) begin
      next_div_cnt = 15'h0000;
      next_tick    = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      div_cnt <= 15'h0000;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  // ==========================================================
  // Register bus
  hfl_bus_t        bus;
  logic            hit, wr_hit, rd_hit;
  logic [NIRQ-1:0] istat, next_istat, ien, next_ien, ev;
  logic [7:0]      rdata, next_rdata;
  logic            drv_en, next_drv_en, dir, next_dir;
  logic [6:0]      tx_sum, next_tx_sum, rx_sum, next_rx_sum;
  logic [6:0]      rx_data, next_rx_data;
  logic            rx_full, next_rx_full, irq, next_irq;
  logic            tx_pend, rx_busy, rx_done;
  hfl_st_t         tx_st;
  logic            dead;

  assign bus    = '{wr: WR_I, rd: RD_I, sel: ADDR_I[7:4],
                    idx: ADDR_I[3:0], wdata: WDATA_I};
  assign hit    = (bus.sel == sw);
  assign wr_hit = bus.wr && hit;
  assign rd_hit = bus.rd && hit;

  always_comb begin
    next_ctrl   = ctrl;
    next_ien    = ien;
    next_rdata  = 8'h00;
    next_drv_en = wr_hit || rd_hit;
    next_dir    = rd_hit;
    next_tx_sum = tx_sum;
    next_rx_sum = rx_sum;
    // Event set wins over a clear in the same cycle
    next_istat  = istat;
    if (wr_hit && bus.idx == REG_ICLR) begin
      next_istat = istat & ~bus.wdata[NIRQ-1:0];
    end
    next_istat = next_istat | ev;
    if (wr_hit) begin
      unique case (bus.idx)
        REG_CTRL:  next_ctrl = hfl_ctrl_t'(bus.wdata);
        REG_IEN:   next_ien  = bus.wdata[NIRQ-1:0];
        REG_TXSUM, REG_RXSUM: begin
          next_tx_sum = 7'h00;
          next_rx_sum = 7'h00;
        end
        default: ;
      endcase
    end
    if (wr_hit && bus.idx == REG_TXD && !tx_pend && tx_st == ST_IDLE) begin
      next_tx_sum = next_tx_sum ^ bus.wdata[6:0];
    end
    if (rx_done) begin
      next_rx_sum = next_rx_sum ^ next_rx_data;
    end
    if (rd_hit) begin
      unique case (bus.idx)
        REG_CTRL:  next_rdata = {4'h0, ctrl[3:0]};
        REG_STAT:  next_rdata = {1'b0, test_on, rx_sum == 7'h00, dead,
                                 cd_on, rx_busy,
                                 tx_pend || tx_st == ST_BUSY, rx_full};
        REG_RXD:   next_rdata = {1'b0, rx_data};
        REG_ISTAT: next_rdata = {3'h0, istat};
        REG_IEN:   next_rdata = {3'h0, ien};
        REG_TXSUM: next_rdata = {1'b0, tx_sum};
        REG_RXSUM: next_rdata = {1'b0, rx_sum};
        default:   next_rdata = 8'h00;
      endcase
    end
    next_irq = |(next_istat & next_ien);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl   <= hfl_ctrl_t'(CTRL_RST);
      ien    <= IEN_RST;
      istat  <= '0;
      rdata  <= 8'h00;
      drv_en <= 1'b0;
      dir    <= 1'b0;
      tx_sum <= 7'h00;
      rx_sum <= 7'h00;
      irq    <= 1'b0;
    end else begin
      ctrl   <= next_ctrl;
      ien    <= next_ien;
      istat  <= next_istat;
      rdata  <= next_rdata;
      drv_en <= next_drv_en;
      dir    <= next_dir;
      tx_sum <= next_tx_sum;
      rx_sum <= next_rx_sum;
      irq    <= next_irq;
    end
  end

  // ==========================================================
  // Transmitter
  hfl_st_t    next_tx_st;
  logic [6:0] tx_hold, next_tx_hold;
  logic [9:0] tx_sh, next_tx_sh;
  logic [3:0] tx_tick, next_tx_tick, tx_bit, next_tx_bit;
  logic       next_tx_pend, txd, next_txd, tx_go, tx_end;

  always_comb begin
    next_tx_st   = tx_st;
    next_tx_hold = tx_hold;
    next_tx_pend = tx_pend;
    next_tx_sh   = tx_sh;
    next_tx_tick = tx_tick;
    next_tx_bit  = tx_bit;
    tx_go        = 1'b0;
    tx_end       = 1'b0;
    if (wr_hit && bus.idx == REG_TXD && !tx_pend && tx_st == ST_IDLE) begin
      next_tx_hold = bus.wdata[6:0];
      next_tx_pend = 1'b1;
    end
    unique case (tx_st)
      ST_IDLE: begin
        // Hold off while the far end talks
        if (tx_pend && ctrl.tx_en && !rx_busy && !cd_on) begin
          tx_go        = 1'b1;
          next_tx_pend = 1'b0;
          next_tx_st   = ST_BUSY;
          next_tx_tick = 4'h0;
          next_tx_bit  = 4'h0;
          next_tx_sh   = {1'b1, ^tx_hold, tx_hold, 1'b0};
        end
      end
      ST_BUSY: begin
        if (tick) begin
          next_tx_tick = tx_tick + 4'h1;
          if (tx_tick == END_TICK) begin
            next_tx_sh  = {1'b1, tx_sh[9:1]};
            next_tx_bit = tx_bit + 4'h1;
            if (tx_bit == LAST_BIT) begin
              tx_end     = 1'b1;
              next_tx_st = ST_IDLE;
            end
          end
        end
      end
    endcase
    next_txd = (next_tx_st == ST_BUSY) ? next_tx_sh[0] : 1'b1;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      tx_st   <= ST_IDLE;
      tx_hold <= 7'h00;
      tx_pend <= 1'b0;
      tx_sh   <= 10'h3ff;
      tx_tick <= 4'h0;
      tx_bit  <= 4'h0;
      txd     <= 1'b1;
    end else begin
      tx_st   <= next_tx_st;
      tx_hold <= next_tx_hold;
      tx_pend <= next_tx_pend;
      tx_sh   <= next_tx_sh;
      tx_tick <= next_tx_tick;
      tx_bit  <= next_tx_bit;
      txd     <= next_txd;
    end
  end

  // ==========================================================
  // Receiver, samples mid-bit on the 16x tick
  hfl_st_t    rx_st, next_rx_st;
  logic [7:0] rx_sh, next_rx_sh;
  logic [3:0] rx_tick, next_rx_tick, rx_bit, next_rx_bit;
  logic       perr, ferr;

  always_comb begin
    next_rx_st   = rx_st;
    next_rx_sh   = rx_sh;
    next_rx_tick = rx_tick;
    next_rx_bit  = rx_bit;
    next_rx_data = rx_data;
    next_rx_full = rx_full;
    rx_done      = 1'b0;
    perr         = 1'b0;
    ferr         = 1'b0;
    if (rd_hit && bus.idx == REG_RXD) begin
      next_rx_full = 1'b0;
    end
    unique case (rx_st)
      ST_IDLE: begin
        // Never listens to itself while sending
        if (ctrl.rx_en && tx_st == ST_IDLE && rx_prev && !rx_lvl) begin
          next_rx_st   = ST_BUSY;
          next_rx_tick = 4'h0;
          next_rx_bit  = 4'h0;
        end
      end
      ST_BUSY: begin
        if (tick) begin
          next_rx_tick = rx_tick + 4'h1;
          if (rx_tick == MID_TICK) begin
            next_rx_bit = rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_lvl) begin
              next_rx_st = ST_IDLE;                    // False start
            end else if (rx_bit == LAST_BIT) begin
              next_rx_st   = ST_IDLE;
              rx_done      = 1'b1;
              next_rx_data = rx_sh[6:0];
              next_rx_full = 1'b1;
              // Software drops the message, and sends no reply, on this
              perr         = ^rx_sh;
              ferr         = !rx_lvl;
            end else if (rx_bit != 4'h0) begin
              next_rx_sh = {rx_lvl, rx_sh[7:1]};
            end
          end
        end
      end
    endcase
  end

  assign rx_busy = (rx_st == ST_BUSY);

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rx_st   <= ST_IDLE;
      rx_sh   <= 8'h00;
      rx_tick <= 4'h0;
      rx_bit  <= 4'h0;
      rx_data <= 7'h00;
      rx_full <= 1'b0;
    end else begin
      rx_st   <= next_rx_st;
      rx_sh   <= next_rx_sh;
      rx_tick <= next_rx_tick;
      rx_bit  <= next_rx_bit;
      rx_data <= next_rx_data;
      rx_full <= next_rx_full;
    end
  end

  // ==========================================================
  // Deadman and modulator keying
  logic [28:0] dm_cnt, next_dm_cnt;
  logic        next_dead, mod_en, next_mod_en, dcd_n, next_dcd_n;

  always_comb begin
    next_dm_cnt = dm_cnt;
    next_dead   = dead;
    if (!ctrl.rts || tx_go || rx_done) begin
      next_dm_cnt = 29'h0;
      next_dead   = 1'b0;
    end else if (!dead) begin
      next_dm_cnt = dm_cnt + 29'h1;
      if (dm_cnt >= 29'(DEADMAN_P - 1)) begin
        next_dead = 1'b1;
      end
    end
    // Test tone overrides both RTS and the deadman
    next_mod_en = test_on || (ctrl.rts && !next_dead);
    next_dcd_n  = !cd_on;
    ev           = '0;
    ev[IRQ_RX]   = rx_done;
    ev[IRQ_TX]   = tx_end;
    ev[IRQ_PERR] = perr;
    ev[IRQ_FERR] = ferr;
    ev[IRQ_DEAD] = next_dead && !dead;
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      dm_cnt <= 29'h0;
      dead   <= 1'b0;
      mod_en <= 1'b0;
      dcd_n  <= 1'b1;
    end else begin
      dm_cnt <= next_dm_cnt;
      dead   <= next_dead;
      mod_en <= next_mod_en;
      dcd_n  <= next_dcd_n;
    end
  end

  // ==========================================================
  // Outputs
  assign RDATA_O      = rdata;
  assign BUS_DRV_EN_O = drv_en;
  assign BUS_DIR_O    = dir;
  assign TXD_O        = txd;
  assign FREQ_SEL_O   = txd;
  assign MOD_EN_O     = mod_en;
  assign DCD_N_O      = dcd_n;
  assign IRQ_O        = irq;

  // ==========================================================
  // Checks
  property p_frame_parity;
    tx_go |=> (^tx_sh[8:1] == 1'b0) && !tx_sh[0] && tx_sh[9];
  endproperty
  a_frame_parity: assert property (p_frame_parity)
    else $error("frame parity or framing bits wrong");

  property p_half_duplex;
    tx_go |-> !rx_busy && !cd_on;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("transmit started while line busy");

  property p_parity_err;
    (rx_done && ^rx_sh) |=> istat[IRQ_PERR];
  endproperty
  a_parity_err: assert property (p_parity_err)
    else $error("parity error not flagged");

  property p_freq_sel;
    FREQ_SEL_O == TXD_O;
  endproperty
  a_freq_sel: assert property (p_freq_sel)
    else $error("frequency select differs from data");

  property p_no_rts_silent;
    (!test_on && !ctrl.rts) |=> !MOD_EN_O;
  endproperty
  a_no_rts_silent: assert property (p_no_rts_silent)
    else $error("modulator on without request to send");

  property p_test_tone;
    test_on |=> MOD_EN_O;
  endproperty
  a_test_tone: assert property (p_test_tone)
    else $error("test tone missing");

  property p_deadman;
    (next_dead && !test_on) |=> !MOD_EN_O;
  endproperty
  a_deadman: assert property (p_deadman)
    else $error("modulator on after deadman trip");

  property p_decode;
    ((RD_I || WR_I) && ADDR_I[7:4] != sw) |=> !BUS_DRV_EN_O && RDATA_O == 8'h00;
  endproperty
  a_decode: assert property (p_decode)
    else $error("answered foreign board address");

  property p_idle_mark;
    (tx_st == ST_IDLE && $past(tx_st) == ST_BUSY) |-> TXD_O && $past(TXD_O);
  endproperty
  a_idle_mark: assert property (p_idle_mark)
    else $error("stop bit or idle level not mark");

  property p_dcd;
    cd_on |=> !DCD_N_O;
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("carrier detect not asserted");

endmodule

//--- design/hfl_pkg.sv
package hfl_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned BAUD_FAST   = 1200;
  localparam int unsigned BAUD_SLOW   = 300;
  localparam int unsigned OVS         = 16;
  localparam int unsigned DIV_FAST    = CLK_HZ / (BAUD_FAST * OVS);
  localparam int unsigned DIV_SLOW    = CLK_HZ / (BAUD_SLOW * OVS);
  localparam int unsigned DEADMAN_MS  = 2500;
  localparam int unsigned DEADMAN_CYC = (CLK_HZ / 1000) * DEADMAN_MS;

  // ==========================================================
  // Frame
  localparam int unsigned DATA_BITS  = 7;
  localparam int unsigned FRAME_BITS = 10;
  localparam logic [3:0]  LAST_BIT   = 4'h9;
  localparam logic [3:0]  MID_TICK   = 4'h7;
  localparam logic [3:0]  END_TICK   = 4'hf;

  // ==========================================================
  // Register map (index on the low address nibble)
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h1;
  localparam logic [3:0] REG_TXD   = 4'h2;
  localparam logic [3:0] REG_RXD   = 4'h3;
  localparam logic [3:0] REG_ISTAT = 4'h4;
  localparam logic [3:0] REG_ICLR  = 4'h5;
  localparam logic [3:0] REG_IEN   = 4'h6;
  localparam logic [3:0] REG_TXSUM = 4'h7;
  localparam logic [3:0] REG_RXSUM = 4'h8;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] IEN_RST  = 5'h00;

  // Interrupt status bits
  localparam int unsigned NIRQ     = 5;
  localparam int unsigned IRQ_RX   = 0;
  localparam int unsigned IRQ_TX   = 1;
  localparam int unsigned IRQ_PERR = 2;
  localparam int unsigned IRQ_FERR = 3;
  localparam int unsigned IRQ_DEAD = 4;

  // Pin vector layout after synchronisation
  localparam int unsigned PIN_RXD  = 0;
  localparam int unsigned PIN_CD   = 1;
  localparam int unsigned PIN_TEST = 2;
  localparam int unsigned PIN_SW   = 3;
  localparam int unsigned NPIN     = 7;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       rts;
    logic       rx_en;
    logic       tx_en;
    logic       baud_slow;
  } hfl_ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] sel;
    logic [3:0] idx;
    logic [7:0] wdata;
  } hfl_bus_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } hfl_st_t;

endpackage

//--- dv/hfl_peer.sv
`timescale 1ns/10ps
// ============================================================
// Far-end terminal modem: demodulated data and carrier toward
// the block, and a decoder for what the block sends.
module hfl_peer (
  input  wire logic clk_i, // Bench clock
  input  wire logic txd_i, // Serial data from the block
  output logic      rxd_o, // Demodulated data, idles at mark
  output logic      car_o  // Tone energy present
);
  initial begin
    rxd_o = 1'b1;
    car_o = 1'b0;
  end

  // Tone rises a bit before the start bit and drops after stop
  task automatic send(input logic [6:0] ch, input logic bad, input int bc);
    logic [9:0] f;
    f = {1'b1, (^ch) ^ bad, ch, 1'b0};
    car_o <= 1'b1;
    repeat (bc) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (bc) @(posedge clk_i);
    end
    car_o <= 1'b0;
  endtask

  // Samples mid-bit; a wrong rate shows up as a wrong frame
  task automatic recv(input int bc, output logic [9:0] f);
    int n;
    n = 0;
    while (txd_i !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (bc / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd_i;
      repeat (bc) @(posedge clk_i);
    end
  endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import hfl_pkg::*;
  // ==========================================================
  // Short counts keep the run brief
  localparam int DF  = 4;
  localparam int DS  = 16;
  localparam int DM  = 2000;
  localparam int BF  = 16 * DF;
  localparam int BS  = 16 * DS;
  localparam int LIM = 40000;

  logic       clk   = 1'b0;
  logic       srst  = 1'b1;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_s  = 1'b0;
  logic       rd_s  = 1'b0;
  logic       test  = 1'b0;
  logic [3:0] sel   = 4'h0;
  logic [3:0] bsw   = 4'h0;
  logic       rxd;
  logic       car;
  logic [7:0] rdata;
  logic       drv_en;
  logic       dir;
  logic       txd;
  logic       freq;
  logic       mod_en;
  logic       dcd_n;
  logic       irq;
  logic [9:0] f;
  int         errors = 0;
  int         checks = 0;
  int         cyc    = 0;

  always #4 clk = ~clk;

  hfl_link #(.DIV_FAST_P(DF), .DIV_SLOW_P(DS), .DEADMAN_P(DM)) i_dut (
    .CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .ADDR_SW_I(bsw), .TEST_SW_I(test),
    .RXD_I(rxd), .CARRIER_I(car), .RDATA_O(rdata),
    .BUS_DRV_EN_O(drv_en), .BUS_DIR_O(dir), .TXD_O(txd),
    .FREQ_SEL_O(freq), .MOD_EN_O(mod_en), .DCD_N_O(dcd_n), .IRQ_O(irq)
  );

  hfl_peer i_peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .car_o(car));

  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin
      addr  <= {sel, a};
      wdata <= d;
      wr_s  <= 1'b1;
    end
    @(posedge clk) wr_s <= 1'b0;
    #1;
    `CHK("wr_drv", sel == bsw, drv_en)
    `CHK("wr_dir", 1'b0, dir)
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic hit;
    hit = (sel == bsw);
    @(posedge clk) begin
      addr <= {sel, a};
      rd_s <= 1'b1;
    end
    @(posedge clk) rd_s <= 1'b0;
    #1;
    `CHK("rdata", hit ? e : 8'h00, rdata)
    `CHK("rd_drv", hit, drv_en)
    `CHK("rd_dir", hit, dir)
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Both outputs come from the one txd register, so they must agree every cycle
  always @(negedge clk) begin
    if (!srst)
      `CHK("freq", txd, freq)
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      errors++;
      stop_test();
    end
  end

  // ==========================================================
  // Register rows: write flag, index, write data, expected read
  logic [20:0] rows [13] = '{
    {1'b0, REG_STAT, 8'h00, 8'h20},
    {1'b0, REG_CTRL, 8'h00, 8'h00}, {1'b0, REG_IEN, 8'h00, 8'h00},
    {1'b0, REG_ISTAT, 8'h00, 8'h00}, {1'b0, REG_TXSUM, 8'h00, 8'h00},
    {1'b0, REG_RXSUM, 8'h00, 8'h00}, {1'b0, 4'hf, 8'h00, 8'h00},
    {1'b1, REG_CTRL, 8'h0b, 8'h00}, {1'b0, REG_CTRL, 8'h00, 8'h0b},
    {1'b1, REG_IEN, 8'h1f, 8'h00}, {1'b0, REG_IEN, 8'h00, 8'h1f},
    {1'b1, 4'hf, 8'hff, 8'h00}, {1'b0, 4'hf, 8'h00, 8'h00}
  };

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("txd", 1'b1, txd)
    `CHK("mod_en", 1'b0, mod_en)
    `CHK("dcd_n", 1'b1, dcd_n)
    `CHK("irq", 1'b0, irq)
    tend("reset");
    foreach (rows[i]) begin
      if (rows[i][20])
        wr(rows[i][19:16], rows[i][15:8]);
      else
        rd(rows[i][19:16], rows[i][7:0]);
    end
    wr(REG_CTRL, 8'h00);
    tend("registers");
    // Foreign board address must leave the registers alone
    sel = 4'h1;
    wr(REG_CTRL, 8'h08);
    rd(REG_CTRL, 8'h00);
    sel = 4'h0;
    rd(REG_CTRL, 8'h00);
    // Moving the selector moves the board
    @(posedge clk) bsw <= 4'h3;
    repeat (8) @(posedge clk);
    rd(REG_CTRL, 8'h00);
    sel = 4'h3;
    rd(REG_CTRL, 8'h00);
    @(posedge clk) bsw <= 4'h0;
    repeat (8) @(posedge clk);
    sel = 4'h0;
    tend("address");
    // ==========================================================
    // Transmit at both rates
    wr(REG_CTRL, 8'h0a);
    wr(REG_IEN, 8'h02);
    fork
      i_peer.recv(BF, f);
      wr(REG_TXD, 8'h31);
    join
    `CHK("frame_f", {1'b1, ^7'h31, 7'h31, 1'b0}, f)
    `CHK("mod_rts", 1'b1, mod_en)
    repeat (BF) @(posedge clk);
    `CHK("irq_tx", 1'b1, irq)
    rd(REG_ISTAT, 8'h02);
    wr(REG_ICLR, 8'h02);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    wr(REG_CTRL, 8'h03);
    fork
      i_peer.recv(BS, f);
      wr(REG_TXD, 8'h5e);
    join
    `CHK("frame_s", {1'b1, ^7'h5e, 7'h5e, 1'b0}, f)
    repeat (BS) @(posedge clk);
    rd(REG_TXSUM, 8'h31 ^ 8'h5e);
    tend("transmit");
    // ==========================================================
    // Receive, good and bad parity
    wr(REG_ICLR, 8'h1f);
    wr(REG_CTRL, 8'h04);
    fork
      i_peer.send(7'h4c, 1'b0, BF);
      begin
        repeat (BF * 3) @(posedge clk);
        `CHK("dcd_on", 1'b0, dcd_n)
      end
    join
    repeat (BF) @(posedge clk);
    `CHK("dcd_off", 1'b1, dcd_n)
    rd(REG_ISTAT, 8'h01);
    rd(REG_RXD, 8'h4c);
    rd(REG_RXSUM, 8'h4c);
    wr(REG_ICLR, 8'h1f);
    i_peer.send(7'h13, 1'b1, BF);
    repeat (BF) @(posedge clk);
    rd(REG_ISTAT, 8'h05);
    tend("receive");
    // ==========================================================
    // A queued character waits until the far end goes quiet
    wr(REG_ICLR, 8'h1f);
    wr(REG_CTRL, 8'h06);
    fork
      i_peer.send(7'h2a, 1'b0, BF);
      begin
        repeat (BF) @(posedge clk);
        wr(REG_TXD, 8'h31);
        repeat (BF * 8) begin
          @(posedge clk);
          `CHK("hdx", 1'b1, txd)
        end
      end
    join
    i_peer.recv(BF, f);
    `CHK("frame_h", {1'b1, ^7'h31, 7'h31, 1'b0}, f)
    repeat (BF) @(posedge clk);
    tend("half_duplex");
    // ==========================================================
    // Test tone, then deadman shutoff with its interrupt
    wr(REG_CTRL, 8'h00);
    test <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("mod_test", 1'b1, mod_en)
    test <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("mod_idle", 1'b0, mod_en)
    wr(REG_ICLR, 8'h1f);
    wr(REG_CTRL, 8'h08);
    repeat (10) @(posedge clk);
    `CHK("mod_on", 1'b1, mod_en)
    repeat (DM + 20) @(posedge clk);
    `CHK("mod_dead", 1'b0, mod_en)
    wr(REG_CTRL, 8'h00);
    rd(REG_ISTAT, 8'h10);
    `CHK("irq_mask", 1'b0, irq)
    wr(REG_IEN, 8'h10);
    repeat (2) @(posedge clk);
    `CHK("irq_dead", 1'b1, irq)
    wr(REG_ICLR, 8'h10);
    repeat (2) @(posedge clk);
    `CHK("irq_off", 1'b0, irq)
    tend("deadman");
    stop_test();
  end
endmodule
